// file: verilog/dmz_pkg.sv
package dmz_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned NUM_GPO = 6;
  localparam int unsigned SAMPLE_W = 24;
  localparam logic [6:0] IDX_CLK_FMT = 7'h09;
  localparam logic [6:0] IDX_FZPD = 7'h0A;
  localparam logic [6:0] IDX_RDIDX = 7'h0B;
  localparam logic [6:0] IDX_OVGPO = 7'h0C;
  localparam int unsigned RW_BIT = 15;
  localparam int unsigned IDX_LSB = 8;
  localparam logic [7:0] CLK_FMT_RST = 8'h00;
  localparam logic [7:0] FZPD_RST = 8'h00;
  localparam logic [7:0] RDIDX_RST = 8'h01;
  localparam logic [7:0] OVGPO_RST = 8'h00;
  localparam int unsigned ZERO_RUN = 1024;
  localparam int unsigned ZCNT_W = 11;
  localparam logic [ZCNT_W-1:0] ZERO_RUN_CNT = ZCNT_W'(ZERO_RUN);

  typedef enum logic [2:0] {
    FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16, FMT_I2S, FMT_LJ, FMT_RSV6, FMT_RSV7
  } dmz_fmt_e;

  typedef struct packed {
    logic [1:0] rsv;
    logic filter_slow;
    logic clock_out_half_rate;
    logic clock_out_disable;
    logic [2:0] audio_format_sel;
  } dmz_clk_fmt_s;

  typedef struct packed {
    logic rsv;
    logic zero_flag_polarity;
    logic output_phase_invert;
    logic [1:0] deemph_rate_sel;
    logic [2:0] deemph_enable;
  } dmz_fzpd_s;

  typedef struct packed {
    logic auto_inc;
    logic [6:0] register_index;
  } dmz_rdidx_s;

  typedef struct packed {
    logic oversample_hi;
    logic gp_output_enable;
    logic [5:0] gp_output_bit;
  } dmz_ovgpo_s;

  typedef struct packed {
    logic rw;
    logic [6:0] idx;
    logic [7:0] data;
  } dmz_word_s;
endpackage : dmz_pkg

// file: verilog/dmz_top.sv
module dmz_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic ctrl_valid,
  input wire dmz_pkg::dmz_word_s ctrl_word,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic word_clock,
  input wire logic [dmz_pkg::NUM_CH*dmz_pkg::SAMPLE_W-1:0] sample_data,
  output logic sys_clock_out_pin,
  output logic [5:0] zero_gpo_pins,
  output logic zero_flag_ch7,
  output logic zero_flag_ch8,
  output logic zero_flag_all,
  output logic [2:0] audio_format_sel,
  output logic output_phase_invert,
  output logic [1:0] deemph_rate_sel,
  output logic deemph_active,
  output logic auto_inc_en,
  output logic [6:0] read_last_index,
  output logic oversample_hi,
  output logic filter_slow
);
  // reset released through two flops so all logic leaves reset together
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  dmz_pkg::dmz_clk_fmt_s clk_fmt_reg, clk_fmt_next;
  dmz_pkg::dmz_fzpd_s fzpd_reg, fzpd_next;
  dmz_pkg::dmz_rdidx_s rdidx_reg, rdidx_next;
  dmz_pkg::dmz_ovgpo_s ovgpo_reg, ovgpo_next;
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] rd_data_reg, rd_data_next;

  // register bank: write on rw=0, read returns addressed byte on rw=1
  always_comb begin
    clk_fmt_next = clk_fmt_reg;
    fzpd_next = fzpd_reg;
    rdidx_next = rdidx_reg;
    ovgpo_next = ovgpo_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    if (ctrl_valid) begin
      if (!ctrl_word.rw) begin
        unique case (ctrl_word.idx)
          dmz_pkg::IDX_CLK_FMT: clk_fmt_next = ctrl_word.data;
          dmz_pkg::IDX_FZPD: fzpd_next = ctrl_word.data;
          dmz_pkg::IDX_RDIDX: rdidx_next = ctrl_word.data;
          dmz_pkg::IDX_OVGPO: ovgpo_next = ctrl_word.data;
          default: ;
        endcase
      end else begin
        rd_valid_next = 1'b1;
        unique case (ctrl_word.idx)
          dmz_pkg::IDX_CLK_FMT: rd_data_next = clk_fmt_reg;
          dmz_pkg::IDX_FZPD: rd_data_next = fzpd_reg;
          dmz_pkg::IDX_RDIDX: rd_data_next = rdidx_reg;
          dmz_pkg::IDX_OVGPO: rd_data_next = ovgpo_reg;
          default: rd_data_next = 8'h00; // unmapped indices read zero
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_fmt_reg <= dmz_pkg::CLK_FMT_RST;
      fzpd_reg <= dmz_pkg::FZPD_RST;
      rdidx_reg <= dmz_pkg::RDIDX_RST;
      ovgpo_reg <= dmz_pkg::OVGPO_RST;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else if (clk_en) begin
      clk_fmt_reg <= clk_fmt_next;
      fzpd_reg <= fzpd_next;
      rdidx_reg <= rdidx_next;
      ovgpo_reg <= ovgpo_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;

  // clock output: toggle divider gives half rate; full rate is modelled as the
  // raw input clock, not gated by clk_en, which a real chip would do with a glitch-free gate
  logic half_reg, half_next;
  always_comb begin
    half_next = ~half_reg;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else if (clk_en) begin
      half_reg <= half_next;
    end
  end
  logic clk_sel;
  assign clk_sel = clk_fmt_reg.clock_out_half_rate ? half_reg : sys_clk;
  assign sys_clock_out_pin = clk_fmt_reg.clock_out_disable ? 1'b0 : clk_sel;

  // mode fields out to the audio path
  assign audio_format_sel = clk_fmt_reg.audio_format_sel;
  assign output_phase_invert = fzpd_reg.output_phase_invert;
  assign deemph_rate_sel = fzpd_reg.deemph_rate_sel;
  assign deemph_active = |fzpd_reg.deemph_enable;
  assign auto_inc_en = rdidx_reg.auto_inc;
  assign read_last_index = rdidx_reg.register_index;
  assign oversample_hi = ovgpo_reg.oversample_hi;
  assign filter_slow = clk_fmt_reg.filter_slow;

  // word-clock rising edge marks one sample period
  logic wc_d_reg, wc_d_next;
  always_comb begin
    wc_d_next = word_clock;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wc_d_reg <= 1'b0;
    end else if (clk_en) begin
      wc_d_reg <= wc_d_next;
    end
  end
  logic wc_rise;
  assign wc_rise = word_clock & ~wc_d_reg;

  // per-channel zero-run counters saturate at the run length
  logic [dmz_pkg::ZCNT_W-1:0] zcnt_reg [dmz_pkg::NUM_CH];
  logic [dmz_pkg::ZCNT_W-1:0] zcnt_next [dmz_pkg::NUM_CH];
  logic [dmz_pkg::NUM_CH-1:0] zdet;
  always_comb begin
    for (int i = 0; i < dmz_pkg::NUM_CH; i++) begin
      zcnt_next[i] = zcnt_reg[i];
      if (sample_data[i*dmz_pkg::SAMPLE_W +: dmz_pkg::SAMPLE_W] != '0) begin
        zcnt_next[i] = '0;
      end else if (wc_rise && zcnt_reg[i] != dmz_pkg::ZERO_RUN_CNT) begin
        zcnt_next[i] = zcnt_reg[i] + 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dmz_pkg::NUM_CH; i++) zcnt_reg[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < dmz_pkg::NUM_CH; i++) zcnt_reg[i] <= zcnt_next[i];
    end
  end
  always_comb begin
    for (int i = 0; i < dmz_pkg::NUM_CH; i++) begin
      zdet[i] = (zcnt_reg[i] == dmz_pkg::ZERO_RUN_CNT);
    end
  end

  // polarity applied after detection so the AND sees true detect states
  logic [dmz_pkg::NUM_CH-1:0] zflag;
  assign zflag = fzpd_reg.zero_flag_polarity ? ~zdet : zdet;
  assign zero_gpo_pins = ovgpo_reg.gp_output_enable ? ovgpo_reg.gp_output_bit : zflag[5:0];
  assign zero_flag_ch7 = zflag[6];
  assign zero_flag_ch8 = zflag[7];
  assign zero_flag_all = fzpd_reg.zero_flag_polarity ? ~(&zdet) : (&zdet);

  AST_WRITE_STORES: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && ctrl_valid && !ctrl_word.rw && ctrl_word.idx == dmz_pkg::IDX_OVGPO
    |=> ovgpo_reg == $past(ctrl_word.data)) else $error("write not stored");
  AST_READ_ANSWERS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && ctrl_valid && ctrl_word.rw |=> rd_valid) else $error("read not answered");
  AST_CLK_DISABLED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_fmt_reg.clock_out_disable |-> !sys_clock_out_pin) else $error("clock out not low");
  AST_HALF_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> half_reg != $past(half_reg)) else $error("divider stuck");
  AST_DEEMPH_OR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    deemph_active == (fzpd_reg.deemph_enable != 3'h0)) else $error("deemph or wrong");
  AST_NONZERO_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && sample_data[0 +: dmz_pkg::SAMPLE_W] != '0 |=> !zdet[0]) else $error("flag not cleared");
  AST_ZERO_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fzpd_reg.zero_flag_polarity |-> zero_flag_all == (&zflag)) else $error("and flag wrong");
  AST_GPO_MUX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovgpo_reg.gp_output_enable |-> zero_gpo_pins == ovgpo_reg.gp_output_bit) else $error("gpo mux");
  AST_POLARITY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    zero_flag_ch8 == (zdet[7] ^ fzpd_reg.zero_flag_polarity)) else $error("polarity wrong");
  AST_DETECT_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(zdet[0]) |-> $past(zcnt_reg[0]) == dmz_pkg::ZERO_RUN_CNT - 1'b1) else $error("run length");
  // the answer pulse must not linger into a cycle without a new read
  AST_RD_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && clk_en && !(ctrl_valid && ctrl_word.rw) |=> !rd_valid) else $error("read pulse too long");
  // saturated counter keeps the flag while the channel stays silent
  AST_ZERO_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && zdet[0] && sample_data[0 +: dmz_pkg::SAMPLE_W] == '0 |=> zdet[0]) else $error("zero flag dropped");
  // with gp outputs off the shared pins must carry the channel flags
  AST_GPO_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ovgpo_reg.gp_output_enable |-> zero_gpo_pins == zflag[5:0]) else $error("zero flags not on pins");
  // a low enable must freeze the zero-run counting as well as the bank
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> zcnt_reg[0] == $past(zcnt_reg[0]) && ovgpo_reg == $past(ovgpo_reg)) else $error("state moved while frozen");
  COV_READ: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_valid);
  COV_GPO: cover property (@(posedge sys_clk) disable iff (!rst_n) ovgpo_reg.gp_output_enable);
  COV_ZDET: cover property (@(posedge sys_clk) disable iff (!rst_n) zdet[0]);
  COV_ALL: cover property (@(posedge sys_clk) disable iff (!rst_n) &zdet);
endmodule : dmz_top

// file: sim/dmz_host.sv
module dmz_host (
  input wire logic sys_clk,
  output logic ctrl_valid,
  output dmz_pkg::dmz_word_s ctrl_word,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle word is a junk pattern, never a clean zero
  initial begin
    ctrl_valid = 1'b0;
    ctrl_word = 16'h5A5A;
  end
  // one word per call, held over exactly the edge that takes it
  task automatic xfer(input logic rw, input logic [6:0] idx, input logic [7:0] d, output logic [8:0] q);
    @(posedge sys_clk);
    #1;
    ctrl_valid = 1'b1;
    ctrl_word = {rw, idx, d};
    @(posedge sys_clk);
    #1;
    ctrl_valid = 1'b0;
    ctrl_word = ~ctrl_word; // released word scrambled so stale data cannot pass
    q = {rd_valid, rd_data};
  endtask : xfer
endmodule : dmz_host

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic word_clock = 1'b0;
  logic [191:0] sample_data = '0;
  logic ctrl_valid, rd_valid, clk_out, z7, z8, za, deemph, ainc, ovs, flt, ph;
  dmz_pkg::dmz_word_s ctrl_word;
  logic [7:0] rd_data;
  logic [5:0] pins;
  logic [2:0] fmt;
  logic [1:0] drate;
  logic [6:0] lidx;
  logic [8:0] q;
  logic [1:0] s;
  int num_errors = 0;
  int comparisons = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  dmz_top i_dmz_top (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .rd_valid(rd_valid), .rd_data(rd_data), .word_clock(word_clock),
    .sample_data(sample_data), .sys_clock_out_pin(clk_out), .zero_gpo_pins(pins), .zero_flag_ch7(z7),
    .zero_flag_ch8(z8), .zero_flag_all(za), .audio_format_sel(fmt), .output_phase_invert(ph),
    .deemph_rate_sel(drate), .deemph_active(deemph), .auto_inc_en(ainc), .read_last_index(lidx),
    .oversample_hi(ovs), .filter_slow(flt));
  dmz_host i_dmz_host (.sys_clk(sys_clk), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
    .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (exp !== got) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    i_dmz_host.xfer(1'b0, idx, d, q);
  endtask : wr
  // read answer must come with its valid pulse in the cycle after the take
  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    i_dmz_host.xfer(1'b1, idx, 8'h00, q);
    chk("read", {1'b1, e}, q);
  endtask : rd
  task automatic t_regs;
    chk("rst_pins", 9'h000, {pins, z7, z8, za});
    rd(7'h09, 8'h00);
    rd(7'h0A, 8'h00);
    rd(7'h0B, 8'h01);
    rd(7'h0C, 8'h00);
    wr(7'h0D, 8'hFF);
    rd(7'h0D, 8'h00);
    wr(7'h0B, 8'h86);
    chk("inc", 9'h106, {ainc, 1'b0, lidx});
    rd(7'h0B, 8'h86);
    wr(7'h0C, 8'h80);
    chk("ovs", 9'h001, {8'h00, ovs});
    rd(7'h0C, 8'h80);
  endtask : t_regs
  // reserved format codes are left out on purpose
  task automatic t_fields;
    for (int f = 0; f < 6; f++) begin
      wr(7'h09, 8'h20 | 8'(f));
      chk("fmt", 9'h008 + 9'(f), {5'h00, flt, fmt});
    end
    for (int d = 0; d < 8; d++) begin
      wr(7'h0A, 8'(d));
      chk("deemph", {8'h00, d != 0}, {8'h00, deemph});
    end
    for (int r = 0; r < 3; r++) begin
      wr(7'h0A, 8'h20 | 8'(r << 3));
      chk("rate_phase", 9'h004 | 9'(r), {6'h00, ph, drate});
    end
    wr(7'h0A, 8'h00);
    wr(7'h09, 8'h00);
  endtask : t_fields
  // clock out sampled just after both edges of sys_clk
  task automatic t_clk;
    s[1] = clk_out;
    @(negedge sys_clk);
    #1;
    s[0] = clk_out;
    chk("full", 9'h002, {7'h00, s});
    wr(7'h09, 8'h10);
    s = {2{clk_out}};
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      s = {s[0], clk_out};
      chk("half", {8'h00, ~s[1]}, {8'h00, s[0]});
    end
    wr(7'h09, 8'h18);
    repeat (4) begin
      @(negedge sys_clk);
      #1;
      chk("off", 9'h000, {8'h00, clk_out});
    end
    wr(7'h09, 8'h00);
  endtask : t_clk
  // one word clock rise every two cycles
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      word_clock = ~word_clock;
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : pulses
  task automatic t_zero;
    pulses(2046);
    chk("zero_1023", 9'h000, {pins, z7, z8, za});
    pulses(2);
    chk("zero_1024", 9'h1FF, {pins, z7, z8, za});
    wr(7'h0A, 8'h40);
    chk("zero_inv", 9'h000, {pins, z7, z8, za});
    wr(7'h0A, 8'h00);
    sample_data[191:168] = 24'h000001;
    pulses(2);
    chk("zero_ch8", 9'h1FC, {pins, z7, z8, za});
    wr(7'h0C, 8'h6A);
    chk("gpo", 9'h02A, {3'h0, pins});
  endtask : t_zero
  // a write while frozen must be lost; the read answer lasts one cycle
  task automatic t_freeze;
    clk_en = 1'b0;
    wr(7'h0C, 8'h15);
    chk("frz_gpo", 9'h02A, {3'h0, pins});
    @(posedge sys_clk);
    #1;
    clk_en = 1'b1;
    rd(7'h0C, 8'h6A);
    @(posedge sys_clk);
    #1;
    chk("rd_pulse", 9'h000, {8'h00, rd_valid});
  endtask : t_freeze
  task automatic results;
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // reset held 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_fields();
    t_clk();
    t_zero();
    t_freeze();
    results();
  end
  // the run needs about 2200 cycles; far past that means a hang
  initial begin
    #(50 * 20000);
    num_errors++;
    results();
  end
endmodule : tb_top
